// File: rtl/sfbs_pkg.sv
// package for the spi flash boot sequencer: register map, opcodes, timing
// assumes a 100 MHz pclk and an APB master of 32-bit data
package sfbs_pkg;
   // register byte offsets
   localparam logic [7:0] SFBS_CTRL_OFF   = 8'h00;  // go, command, select
   localparam logic [7:0] SFBS_ADDR_OFF   = 8'h04;  // flash byte address
   localparam logic [7:0] SFBS_COUNT_OFF  = 8'h08;  // data bytes to move
   localparam logic [7:0] SFBS_WDATA_OFF  = 8'h0c;  // program data byte
   localparam logic [7:0] SFBS_RDATA_OFF  = 8'h10;  // read data byte
   localparam logic [7:0] SFBS_STATUS_OFF = 8'h14;  // block state
   // control field positions
   localparam int SFBS_CTRL_GO     = 0;
   localparam int SFBS_CTRL_CMD_LO = 1;
   localparam int SFBS_CTRL_CMD_HI = 3;
   localparam int SFBS_CTRL_SEL    = 4;
   localparam int SFBS_CTRL_FAST   = 5;
   // flash opcodes
   localparam logic [7:0] SFBS_OP_WENABLE = 8'h06;
   localparam logic [7:0] SFBS_OP_STREAD  = 8'h05;
   localparam logic [7:0] SFBS_OP_STWRITE = 8'h01;
   localparam logic [7:0] SFBS_OP_READ  = 8'h0b;
   localparam logic [7:0] SFBS_OP_PROG  = 8'h02;
   localparam logic [7:0] SFBS_OP_SERA  = 8'h20;
   localparam logic [7:0] SFBS_OP_CERA  = 8'hc7;
   // status bits of the flash
   localparam int SFBS_BUSY_FLAG_BIT   = 0;
   localparam int SFBS_WRITE_LATCH_BIT = 1;
   // geometry
   localparam int SFBS_ADDR_W    = 24;
   localparam int SFBS_PAGE_SIZE = 256;
   // serial clock rates and derived half periods in pclk cycles
   localparam int SFBS_PCLK_KHZ  = 100000;
   localparam int SFBS_SLOW_KHZ  = 1420;
   localparam int SFBS_FAST_KHZ  = 30000;
   localparam int SFBS_SLOW_HALF = (SFBS_PCLK_KHZ + 2*SFBS_SLOW_KHZ - 1) / (2*SFBS_SLOW_KHZ);
   localparam int SFBS_FAST_HALF = (SFBS_PCLK_KHZ + 2*SFBS_FAST_KHZ - 1) / (2*SFBS_FAST_KHZ);
   // select high time between frames
   localparam int SFBS_DESEL_NS  = 200;
   localparam int SFBS_DESEL_CYC = (SFBS_DESEL_NS * SFBS_PCLK_KHZ + 999999) / 1000000;
   // user commands
   typedef enum logic [2:0] {
      SFBS_C_READ, SFBS_C_PROG, SFBS_C_SERA, SFBS_C_CERA, SFBS_C_STREAD
   } sfbs_cmd_e;
   typedef enum logic [3:0] {
      SFBS_S_RST, SFBS_S_BOOT, SFBS_S_IDLE, SFBS_S_WENABLE, SFBS_S_POLL,
      SFBS_S_STWRITE, SFBS_S_CMD, SFBS_S_XFER, SFBS_S_GAP, SFBS_S_DONE
   } sfbs_state_e;
   // serial pin group
   typedef struct packed {
      logic sclk;
      logic mosi;
      logic cs0_n;
      logic cs1_n;
   } sfbs_pins_s;
endpackage

// File: rtl/sfbs_top.sv
// spi flash boot sequencer: boot copy, unprotect, program and erase
// assumes an APB master on pclk and a mode 0 serial flash on the pins
//
// Functional notes
// - 24-bit addresses reach 16 MB flash
// - serial clock starts 1.39 MHz, later 25 MHz
// - two selects, boot always on zero
// - copy code first, then signal init start
// - single data line each direction
// - mode 0: idle low, change falling
// - status bit 0 is busy
// - status bit 1 is write latch
// - one status byte per command only
// - boot: enable, poll latch, write zero status
// - enable and poll before program, erase
// - reset low floats clock, data, select zero
`default_nettype none
module sfbs_top
   import sfbs_pkg::*;
#(
   parameter int BOOT_BYTES = 4096  // bytes copied at boot
)(
   input  wire logic        pclk,                  // system clock
   input  wire logic        presetn,               // async reset, low
   input  wire logic        psel,                  // apb select
   input  wire logic        penable,               // apb enable
   input  wire logic        pwrite,                // apb direction
   input  wire logic [7:0]  paddr,                 // apb address
   input  wire logic [31:0] pwdata,                // apb write data
   output logic      [31:0] prdata,                // apb read data
   output logic             pready,                // apb ready
   output logic             pslverr,               // apb error
   input  wire logic        flash_serial_in,       // flash data to us
   output logic             flash_serial_clock,    // serial clock
   output logic             flash_serial_clock_oe_n, // low drives clock
   output logic             flash_serial_out,      // data to flash
   output logic             flash_serial_out_oe_n, // low drives data
   output logic             boot_flash_select_n,   // select zero
   output logic             boot_flash_select_oe_n,// low drives select zero
   output logic             second_flash_select_n, // select one
   output logic             boot_mem_we,           // program memory write
   output logic [15:0]      boot_mem_addr,         // program memory index
   output logic [7:0]       boot_mem_data,         // program memory byte
   output logic             init_start             // auto-init may run
);
   typedef struct packed {
      sfbs_state_e       st;
      sfbs_state_e       after;       // state that launched the current frame
      logic [1:0]        miso_sync;
      logic              fast;
      logic              sel1;
      logic [2:0]        cmd;
      logic [SFBS_ADDR_W-1:0] addr;
      logic [SFBS_ADDR_W-1:0] count;
      logic [7:0]        wdata;
      logic [7:0]        rdata;
      logic [7:0]        status;
      logic              busy;
      logic [5:0]        div;
      logic              sclk;
      logic [7:0]        sh_out;
      logic [7:0]        sh_in;
      logic [2:0]        bit_cnt;
      logic [2:0]        byte_idx;    // header byte index
      logic [2:0]        hdr_len;
      logic              in_data;
      logic              cs_n;
      logic              frame_dir_rd;
      logic              wdata_ok;    // program byte ready
      logic [15:0]       mem_addr;
      logic              mem_we;
      logic              init;
      logic              pready;
      logic [31:0]       prdata;
      logic              booting;
   } sfbs_state_s;

   sfbs_state_s s_reg, s_next;

   // header byte for the current frame
   function automatic logic [7:0] hdr_byte(input logic [7:0] op, input logic [2:0] i,
                                           input logic [SFBS_ADDR_W-1:0] a);
      case (i)
         3'd0:    hdr_byte = op;
         3'd1:    hdr_byte = a[23:16];
         3'd2:    hdr_byte = a[15:8];
         3'd3:    hdr_byte = a[7:0];
         default: hdr_byte = 8'h00;  // dummy byte
      endcase
   endfunction

   // opcode of a user command
   function automatic logic [7:0] cmd_op(input logic [2:0] c);
      case (c)
         SFBS_C_READ: cmd_op = SFBS_OP_READ;
         SFBS_C_PROG: cmd_op = SFBS_OP_PROG;
         SFBS_C_SERA: cmd_op = SFBS_OP_SERA;
         SFBS_C_CERA: cmd_op = SFBS_OP_CERA;
         default:     cmd_op = SFBS_OP_STREAD;
      endcase
   endfunction

   // header length per opcode
   function automatic logic [2:0] op_len(input logic [7:0] op);
      if (op == SFBS_OP_READ)
         op_len = 3'd5;
      else if (op == SFBS_OP_PROG || op == SFBS_OP_SERA)
         op_len = 3'd4;
      else
         op_len = 3'd1;
      return op_len;
   endfunction

   logic       apb_wr;
   logic       apb_rd;
   logic [5:0] half;
   logic       miso;
   logic [7:0] cur_op;
   logic [7:0] in_byte;

   // apb strobes and synchronised serial input
   assign apb_wr = psel && penable && pwrite && !s_reg.pready;
   assign apb_rd = psel && penable && !pwrite && !s_reg.pready;
   assign half   = s_reg.fast ? 6'(SFBS_FAST_HALF) : 6'(SFBS_SLOW_HALF);
   assign miso   = s_reg.miso_sync[1];
   assign in_byte = {s_reg.sh_in[6:0], miso};  // byte with the newest bit

   // next state
   always_comb
   begin
      s_next = s_reg;
      s_next.miso_sync = {s_reg.miso_sync[0], flash_serial_in};
      s_next.mem_we = 1'b0;
      s_next.pready = 1'b0;
      cur_op = SFBS_OP_STREAD;

      // register bus
      if (apb_rd)
      begin
         s_next.pready = 1'b1;
         if (paddr == SFBS_ADDR_OFF)
            s_next.prdata = {8'h00, s_reg.addr};
         else if (paddr == SFBS_COUNT_OFF)
            s_next.prdata = {8'h00, s_reg.count};
         else if (paddr == SFBS_RDATA_OFF)
            s_next.prdata = {24'h000000, s_reg.rdata};
         else if (paddr == SFBS_STATUS_OFF)
            s_next.prdata = {24'h000000, s_reg.st, s_reg.wdata_ok, s_reg.init,
                             s_reg.busy, s_reg.status[SFBS_BUSY_FLAG_BIT]};
         else
            s_next.prdata = 32'h00000000;
      end
      else if (apb_wr)
      begin
         s_next.pready = 1'b1;
         if (paddr == SFBS_CTRL_OFF && s_reg.st == SFBS_S_IDLE && pwdata[SFBS_CTRL_GO])
         begin
            s_next.cmd  = pwdata[SFBS_CTRL_CMD_HI:SFBS_CTRL_CMD_LO];
            s_next.sel1 = pwdata[SFBS_CTRL_SEL];
            s_next.busy = 1'b1;
         end
         else if (paddr == SFBS_CTRL_OFF)
            s_next.fast = (pwdata[SFBS_CTRL_FAST] & s_reg.init) | s_reg.fast;
         else if (paddr == SFBS_ADDR_OFF)
            s_next.addr = pwdata[SFBS_ADDR_W-1:0];
         else if (paddr == SFBS_COUNT_OFF)
            s_next.count = pwdata[SFBS_ADDR_W-1:0];
         else if (paddr == SFBS_WDATA_OFF)
         begin
            s_next.wdata = pwdata[7:0];
            s_next.wdata_ok = 1'b1;
         end
      end

      // opcode of the frame being launched; the user command's opcode otherwise
      case (s_reg.st)
         SFBS_S_WENABLE: cur_op = SFBS_OP_WENABLE;
         SFBS_S_POLL:    cur_op = SFBS_OP_STREAD;
         SFBS_S_STWRITE: cur_op = SFBS_OP_STWRITE;
         SFBS_S_BOOT: cur_op = SFBS_OP_READ;
         default:     cur_op = cmd_op(s_reg.cmd);
      endcase

      case (s_reg.st)
         SFBS_S_RST:
         begin
            // boot: unprotect first, then copy the image
            s_next.booting = 1'b1;
            s_next.sel1    = 1'b0;
            s_next.st      = SFBS_S_WENABLE;
         end
         SFBS_S_IDLE:
         begin
            if (s_reg.busy)
               s_next.st = (s_reg.cmd == SFBS_C_READ || s_reg.cmd == SFBS_C_STREAD)
                           ? SFBS_S_CMD : SFBS_S_WENABLE;
         end
         SFBS_S_WENABLE, SFBS_S_POLL, SFBS_S_STWRITE, SFBS_S_CMD, SFBS_S_BOOT:
         begin
            // start a frame: load first byte, select low
            s_next.sh_out   = cur_op;
            s_next.byte_idx = 3'd0;
            s_next.bit_cnt  = 3'd0;
            s_next.div      = 6'd0;
            s_next.sclk     = 1'b0;
            s_next.in_data  = 1'b0;
            s_next.cs_n     = 1'b0;
            s_next.hdr_len  = op_len(cur_op);
            s_next.frame_dir_rd = (cur_op == SFBS_OP_READ || cur_op == SFBS_OP_STREAD);
            if (s_reg.st == SFBS_S_BOOT)
            begin
               s_next.addr  = '0;
               s_next.count = SFBS_ADDR_W'(BOOT_BYTES);
            end
            s_next.after = s_reg.st;
            s_next.st    = SFBS_S_XFER;
         end
         SFBS_S_XFER:
         begin
            if (s_reg.div == half - 6'd1)
            begin
               s_next.div  = 6'd0;
               s_next.sclk = !s_reg.sclk;
               // take the bit as sclk falls: the synchroniser lags the pin two clocks
               if (s_reg.sclk)
                  s_next.sh_in = in_byte;
               if (s_reg.sclk && s_reg.bit_cnt != 3'd7)
               begin
                  // falling edge: shift out next bit
                  s_next.bit_cnt = s_reg.bit_cnt + 3'd1;
                  s_next.sh_out  = {s_reg.sh_out[6:0], 1'b0};
               end
               else if (s_reg.sclk)
               begin
                  // byte boundary
                  s_next.bit_cnt = 3'd0;
                  if (!s_reg.in_data && s_reg.byte_idx + 3'd1 < s_reg.hdr_len)
                  begin
                     s_next.byte_idx = s_reg.byte_idx + 3'd1;
                     s_next.sh_out = hdr_byte(cur_op, s_reg.byte_idx + 3'd1, s_reg.addr);
                  end
                  else if (s_reg.after == SFBS_S_POLL || s_reg.after == SFBS_S_STWRITE
                           || (s_reg.after == SFBS_S_CMD && s_reg.cmd == SFBS_C_STREAD))
                  begin
                     // one status byte only, sent or received after the opcode
                     if (s_reg.in_data)
                        s_next.st = SFBS_S_GAP;
                     s_next.in_data = 1'b1;
                     s_next.sh_out  = 8'h00;
                     if (s_reg.in_data && s_reg.after != SFBS_S_STWRITE)
                        s_next.status = in_byte;
                  end
                  else if (s_reg.hdr_len == 3'd1 || s_reg.after == SFBS_S_WENABLE
                           || cur_op == SFBS_OP_SERA || cur_op == SFBS_OP_CERA)
                     s_next.st = SFBS_S_GAP;
                  else
                  begin
                     // data phase, address auto-increments
                     if (s_reg.in_data)
                     begin
                        s_next.addr  = s_reg.addr + 24'd1;
                        s_next.count = s_reg.count - 24'd1;
                        if (s_reg.frame_dir_rd)
                        begin
                           s_next.rdata = in_byte;
                           s_next.mem_we = s_reg.booting;
                           s_next.mem_addr = s_reg.addr[15:0];
                        end
                     end
                     s_next.in_data = 1'b1;
                     s_next.sh_out  = s_reg.wdata;
                     s_next.wdata_ok = apb_wr && paddr == SFBS_WDATA_OFF;  // new byte wins
                     if (s_reg.in_data && (s_reg.count == 24'd1
                         || (!s_reg.frame_dir_rd && s_reg.addr[7:0] == 8'hff)))
                        s_next.st = SFBS_S_GAP;
                  end
               end
            end
            else
               s_next.div = s_reg.div + 6'd1;
         end
         SFBS_S_GAP:
         begin
            // select high for the deselect time
            s_next.cs_n = 1'b1;
            s_next.sclk = 1'b0;
            s_next.div  = s_reg.div + 6'd1;
            if (s_reg.div >= 6'(SFBS_DESEL_CYC))
            begin
               s_next.div = 6'd0;
               s_next.st  = SFBS_S_DONE;
            end
         end
         default:
         begin
            // frame finished: decide the next one
            case (s_reg.after)
               SFBS_S_WENABLE: s_next.st = SFBS_S_POLL;
               SFBS_S_POLL:
                  if (s_reg.status[SFBS_WRITE_LATCH_BIT])
                     s_next.st = s_reg.booting ? SFBS_S_STWRITE : SFBS_S_CMD;
                  else
                     s_next.st = SFBS_S_POLL;
               SFBS_S_STWRITE: s_next.st = SFBS_S_BOOT;
               SFBS_S_BOOT:
               begin
                  s_next.booting = 1'b0;
                  s_next.init    = 1'b1;
                  s_next.fast    = 1'b1;
                  s_next.st      = SFBS_S_IDLE;
               end
               default:
               begin
                  s_next.busy = 1'b0;
                  s_next.st   = SFBS_S_IDLE;
               end
            endcase
         end
      endcase
   end

   // state register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_reg       <= '0;
         s_reg.st    <= SFBS_S_RST;
         s_reg.after <= SFBS_S_RST;
         s_reg.cs_n  <= 1'b1;
      end
      else
         s_reg <= s_next;
   end

   // pin outputs; enables come from reset-held flops so they float in reset
   logic oe_n_reg;
   logic [1:0] cs_reg;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         oe_n_reg <= 1'b1;
         cs_reg   <= 2'b11;
      end
      else
      begin
         oe_n_reg <= 1'b0;
         cs_reg   <= {s_next.cs_n | !s_next.sel1, s_next.cs_n | s_next.sel1};
      end
   end

   assign flash_serial_clock      = s_reg.sclk;
   assign flash_serial_clock_oe_n = oe_n_reg;
   assign flash_serial_out        = s_reg.sh_out[7];
   assign flash_serial_out_oe_n   = oe_n_reg;
   assign boot_flash_select_n     = cs_reg[0];
   assign boot_flash_select_oe_n  = oe_n_reg;
   assign second_flash_select_n   = cs_reg[1];
   assign boot_mem_we             = s_reg.mem_we;
   assign boot_mem_addr           = s_reg.mem_addr;
   assign boot_mem_data           = s_reg.rdata;
   assign init_start              = s_reg.init;
   assign prdata                  = s_reg.prdata;
   assign pready                  = s_reg.pready;
   assign pslverr                 = 1'b0;

   // clock idles low whenever the select is high
   a_sclk_idle_low: assert property (@(posedge pclk) disable iff (!presetn)
      s_reg.cs_n |-> !s_reg.sclk) else $error("serial clock high while deselected");
   // init only after boot copy
   a_init_after_copy: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_reg.init) |-> !s_reg.booting) else $error("init raised during boot");
   // write status only after latch seen
   a_stwrite_after_latch: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.st == SFBS_S_STWRITE) |-> s_reg.status[SFBS_WRITE_LATCH_BIT])
      else $error("status write without latch");
   // program command only after latch seen
   a_prog_after_latch: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.st == SFBS_S_CMD && s_reg.cmd inside {SFBS_C_PROG, SFBS_C_SERA, SFBS_C_CERA})
      |-> s_reg.status[SFBS_WRITE_LATCH_BIT]) else $error("write without latch");
   // boot frames use select zero
   a_boot_sel_zero: assert property (@(posedge pclk) disable iff (!presetn)
      s_reg.booting |-> ##1 second_flash_select_n) else $error("boot on select one");
   // slow rate during boot
   a_boot_slow: assert property (@(posedge pclk) disable iff (!presetn)
      s_reg.booting |-> !s_reg.fast) else $error("fast clock during boot");
   // apb answers one cycle after access
   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready) else $error("apb answer late");
   // outputs driven after reset
   a_pins_driven: assert property (@(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> !flash_serial_out_oe_n) else $error("pins float out of reset");
endmodule // sfbs_top
`default_nettype wire

// File: dv/sfbs_flash_model.sv
// behavioural mode 0 single-bit serial flash for the sequencer bench
// assumes the bench resolves floating pins; hold and protect pins pulled high
`default_nettype none
module sfbs_flash_model (
   input  wire logic sck,   // serial clock
   input  wire logic cs_n,  // select, low
   input  wire logic mosi,  // data to flash
   output var  logic miso   // data from flash
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0]  mem [0:255];
   logic [7:0]  status = 8'h9c;  // protected at power-up
   logic [7:0]  op = 8'h00;
   logic [7:0]  sh, out_sh, wr_val;
   logic [23:0] addr;
   int          nbit;
   int          n_ignored = 0;
   // preload a known image
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'h5a ^ 8'(i);
      miso = 1'b0;
   end
   // frame start
   always @(negedge cs_n)
   begin
      nbit = 0;
      out_sh = 8'h55;
   end
   // sample on rising edge, msb first
   always @(posedge sck)
   begin
      if (!cs_n)
      begin
         sh = {sh[6:0], mosi};
         nbit++;
         if (nbit % 8 == 0)
            take_byte(nbit / 8);
      end
   end
   task automatic take_byte(input int k);
      if (k == 1)
         op = sh;
      else if (op == 8'h01 && k == 2)
         wr_val = sh;
      else if (k <= 4)
         addr = {addr[15:0], sh};
      else if (op == 8'h02 && status[1] && status[6:2] == 5'h00)
      begin
         mem[addr[7:0]] = mem[addr[7:0]] & sh;
         addr[7:0] = addr[7:0] + 8'h01;  // wraps inside the page
      end
      if (op == 8'h05)
         out_sh = status;
      else if (op == 8'h0b && k >= 5)
      begin
         out_sh = mem[addr[7:0]];
         addr = addr + 24'h1;
      end
   endtask
   // change on falling edge
   always @(negedge sck)
   begin
      if (!cs_n)
      begin
         miso = out_sh[7];
         out_sh = {out_sh[6:0], ~out_sh[7]};
      end
   end
   // frame end: commit; released line shows the inverse
   always @(posedge cs_n)
   begin
      miso = ~miso;
      if (op == 8'h06 && nbit == 8)
         status[1] = 1'b1;
      else if (op == 8'h01 && nbit == 16 && status[1])
         status = wr_val & 8'hfd;  // lock inert with protect pin high
      else if (op inside {8'h02, 8'h20, 8'hc7})
      begin
         if (!status[1] || status[6:2] != 5'h00)
            n_ignored++;
         else if (op != 8'h02)
            for (int i = 0; i < 256; i++)
               mem[i] = 8'hff;
         status[1] = 1'b0;
      end
      op = 8'h00;
   end
endmodule // sfbs_flash_model
`default_nettype wire

// File: dv/sfbs_top_tb_top.sv
// self-checking bench for the spi flash boot sequencer
// assumes the flash model on select zero; floating pins resolved here
`default_nettype none
module sfbs_top_tb_top;
   import sfbs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, miso;
   logic        sck, sck_oe_n, mosi, mosi_oe_n, cs0_n, cs0_oe_n, cs1_n, bm_we, init_start;
   logic [7:0]  paddr, bm_data;
   logic [15:0] bm_addr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  boot_img [0:3];
   int          n_fail, compares;
   int          n_cs0_low = 0;
   int          n_cs1_low = 0;
   wire logic   sck_w  = sck_oe_n ? 1'b0 : sck;
   wire logic   cs_w   = cs0_oe_n ? 1'b1 : cs0_n;
   wire logic   mosi_w = mosi_oe_n ? 1'b1 : mosi;
   sfbs_top #(.BOOT_BYTES(4)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .flash_serial_in(miso), .flash_serial_clock(sck), .flash_serial_clock_oe_n(sck_oe_n),
      .flash_serial_out(mosi), .flash_serial_out_oe_n(mosi_oe_n),
      .boot_flash_select_n(cs0_n), .boot_flash_select_oe_n(cs0_oe_n),
      .second_flash_select_n(cs1_n), .boot_mem_we(bm_we), .boot_mem_addr(bm_addr),
      .boot_mem_data(bm_data), .init_start(init_start));
   sfbs_flash_model u_flash (.sck(sck_w), .cs_n(cs_w), .mosi(mosi_w), .miso(miso));
   // clock
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // capture program memory writes
   always @(posedge pclk)
      if (bm_we === 1'b1)
         boot_img[bm_addr[1:0]] <= bm_data;
   // count select-low cycles on each line
   always @(posedge pclk)
   begin
      if (cs0_n === 1'b0)
         n_cs0_low++;
      if (cs1_n === 1'b0)
         n_cs1_low++;
   end
   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // start a command and wait until the block is no longer busy
   task automatic run(input logic [2:0] cmd, input logic [23:0] a, input logic [7:0] wd,
                      input logic sel = 1'b0);
      apb(1'b1, SFBS_ADDR_OFF, {8'h00, a});
      apb(1'b1, SFBS_COUNT_OFF, 32'h1);
      apb(1'b1, SFBS_WDATA_OFF, {24'h0, wd});
      apb(1'b1, SFBS_CTRL_OFF, {26'h0, 1'b1, sel, cmd, 1'b1});
      for (int i = 0; i < 3000; i++)
      begin
         apb(1'b0, SFBS_STATUS_OFF, 32'h0);
         if (rd[1] === 1'b0)
            break;
      end
      chk("busy clear", {31'h0, rd[1]}, 32'h0);
   endtask
   task automatic t_boot();
      for (int i = 0; i < 40000 && init_start !== 1'b1; i++)
         @(posedge pclk);
      chk("init_start", {31'h0, init_start}, 32'h1);
      for (int i = 0; i < 4; i++)
         chk("boot byte", {24'h0, boot_img[i]}, {24'h0, 8'h5a ^ 8'(i)});
      chk("flash status", {24'h0, u_flash.status}, 32'h0);
   endtask
   task automatic t_access();
      int cs0_before;
      run(SFBS_C_READ, 24'h000002, 8'h00);
      apb(1'b0, SFBS_RDATA_OFF, 32'h0);
      chk("read byte", {24'h0, rd[7:0]}, 32'h58);
      run(SFBS_C_PROG, 24'h000010, 8'h3c);
      chk("prog byte", {24'h0, u_flash.mem[16]}, 32'h08);
      run(SFBS_C_PROG, 24'h000011, 8'h0f);
      chk("prog again", {24'h0, u_flash.mem[17]}, 32'h0b);
      run(SFBS_C_SERA, 24'h000010, 8'h00);
      chk("sector erase", {24'h0, u_flash.mem[16]}, 32'hff);
      run(SFBS_C_PROG, 24'h000000, 8'h00);
      run(SFBS_C_CERA, 24'h000000, 8'h00);
      chk("chip erase", {24'h0, u_flash.mem[0]}, 32'hff);
      chk("ignored", 32'(u_flash.n_ignored), 32'h0);
      run(SFBS_C_STREAD, 24'h000000, 8'h00);
      chk("status reg", {24'h0, rd[7:0]}, {24'h0, 4'(SFBS_S_IDLE), 4'b1100});
      cs0_before = n_cs0_low;
      run(SFBS_C_STREAD, 24'h000000, 8'h00, 1'b1);
      chk("sel zero idle", 32'(n_cs0_low - cs0_before), 32'h0);
      chk("sel one used", {31'h0, n_cs1_low > 0}, 32'h1);
      apb(1'b0, 8'h3c, 32'h0);
      chk("unmapped", rd, 32'h0);
      chk("slverr", {31'h0, pslverr}, 32'h0);
   endtask
   // watchdog
   initial
   begin
      #900000;
      n_fail++;
      end_of_test();
   end
   // main sequence, reset checks while held
   initial
   begin
      n_fail = 0;
      compares = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (8) @(posedge pclk);
      chk("oe in reset", {29'h0, sck_oe_n, mosi_oe_n, cs0_oe_n}, 32'h7);
      chk("sel1 in reset", {31'h0, cs1_n}, 32'h1);
      presetn <= 1'b1;
      t_boot();
      t_access();
      end_of_test();
   end
endmodule // sfbs_top_tb_top
`default_nettype wire
